// ===== src/sqp_pkg.sv
// Constants for the shared queue resource policing block.
// Assumes a single clock domain and an AHB-Lite register slave.
package sqp_pkg;
	localparam int NPORT = 4;
	localparam int NQ = 2;
	localparam int NGRP = 4;
	localparam int PW = 2;
	localparam int CW = 20;
	localparam int LW = 14;
	// Watermark groups, identical layout for settings and statistics
	localparam int G_BUF_I = 0;
	localparam int G_REF_I = 1;
	localparam int G_BUF_E = 2;
	localparam int G_REF_E = 3;
	localparam int K_RSV = 0;
	localparam int K_SHR = 1;
	localparam logic [CW-1:0] MEM_TOTAL = 20'h80000;
	localparam logic [CW-1:0] REF_TOTAL = 20'h0157C;
	localparam logic [CW-1:0] LEVEL_RST = 20'hFFFFF;
	localparam logic [NPORT-1:0] MASK_RST = 4'h0;
	localparam logic [NPORT*NQ-1:0] CUT_RST = 8'h00;
	localparam logic [LW-1:0] CUT_LEN = 14'h005C;
	// Register byte offsets
	localparam logic [11:0] OFF_FORCE = 12'h000;
	localparam logic [11:0] OFF_IGR_RSV = 12'h004;
	localparam logic [11:0] OFF_EGR_RSV = 12'h008;
	localparam logic [11:0] OFF_PREFER = 12'h00C;
	localparam logic [11:0] OFF_CUT = 12'h010;
	localparam logic [11:0] OFF_DRAIN = 12'h014;
	localparam logic [11:0] OFF_HOLD = 12'h018;
	localparam logic [11:0] OFF_TOT_SET = 12'h01C;
	localparam logic [11:0] OFF_TOT_CLR = 12'h020;
	localparam logic [11:0] OFF_TOT_TAIL = 12'h024;
	localparam logic [11:0] OFF_FREE_MEM = 12'h028;
	localparam logic [11:0] OFF_FREE_REF = 12'h02C;
	localparam logic [11:0] OFF_STATUS = 12'h030;
	localparam logic [11:0] OFF_WM = 12'h040;
	localparam logic [11:0] OFF_P_START = 12'h060;
	localparam logic [11:0] OFF_P_STOP = 12'h070;
	localparam logic [11:0] OFF_P_TAIL = 12'h080;
	localparam logic [11:0] OFF_CUR = 12'h100;
	localparam logic [11:0] OFF_PEAK = 12'h140;
	typedef enum logic [2:0] {
		SQP_ACCEPT = 3'b001,
		SQP_HOLD = 3'b010,
		SQP_DROP = 3'b100
	} sqp_verdict_e;
	typedef enum logic [2:0] {
		SQP_BUS_IDLE = 3'b001,
		SQP_BUS_WR = 3'b010,
		SQP_BUS_RD = 3'b100
	} sqp_bus_e;
endpackage

// ===== src/sqp_policer.sv
// Resource policing for a switch's shared frame queue system.
// Assumes the enqueue/dequeue datapath shares hclk and reports events
// as one-cycle strobes; the port MACs act on the pause requests.
//
// Behaviour
// - Four watermark groups share one identical layout.
// - Current and peak consumption readable per watermark.
// - Free memory and free references are readable.
// - Flow-controlled frames held; forced-discard egress drops.
// - Ingress reserved-only ports see shared exceeded.
// - Egress reserved-only ports see shared exceeded.
// - Round robin among sources; preferred sources first.
// - Cut-enabled queues truncate frames to 92 bytes.
// - Drain disable stops dequeuing on that port.
// - Depletion drops in drop mode, holds with hold enable, drops otherwise.
// - Hold enable selects holding and enables pause.
// - Total flag sets above set level.
// - Total flag clears below clear level.
// - Pause asserts with flag and port above start.
// - Pause deasserts when port falls below stop.
// - Tail drop applies to all ports regardless of mode bits.
// - Tail drop when port and total exceed levels.
// - Copy made only when memory and references pass.
`timescale 1ns/1ps
module sqp_policer (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Admission request
	input wire logic adm_valid,
	input wire logic [sqp_pkg::PW-1:0] adm_src,
	input wire logic [sqp_pkg::PW-1:0] adm_dst,
	output logic adm_done,
	output sqp_pkg::sqp_verdict_e adm_verdict,
	// Frame data write beats
	input wire logic wr_valid,
	input wire logic wr_last,
	input wire logic [sqp_pkg::PW-1:0] wr_src,
	input wire logic [sqp_pkg::PW-1:0] wr_dst,
	input wire logic [sqp_pkg::LW-1:0] wr_bytes,
	output logic wr_done,
	output logic wr_discard,
	// Resource release
	input wire logic rel_valid,
	input wire logic rel_frame,
	input wire logic [sqp_pkg::PW-1:0] rel_src,
	input wire logic [sqp_pkg::PW-1:0] rel_dst,
	input wire logic [sqp_pkg::LW-1:0] rel_bytes,
	// Source arbitration
	input wire logic arb_valid,
	input wire logic [sqp_pkg::NPORT-1:0] arb_req,
	output logic arb_done,
	output logic [sqp_pkg::NPORT-1:0] arb_gnt,
	// Dequeue request
	input wire logic dq_valid,
	input wire logic [sqp_pkg::PW-1:0] dq_port,
	input wire logic [0:0] dq_queue,
	input wire logic [sqp_pkg::LW-1:0] dq_len,
	output logic dq_done,
	output logic dq_ok,
	output logic [sqp_pkg::LW-1:0] dq_len_out,
	// Pause requests to port modules
	output logic [sqp_pkg::NPORT-1:0] pause_req
);
	import sqp_pkg::*;

	// ----------------------------------------
	// Configuration and state
	// ----------------------------------------
	logic [NPORT-1:0] egress_forced_discard_r;
	logic [NPORT-1:0] ingress_reserved_only_mask_r;
	logic [NPORT-1:0] egress_reserved_only_mask_r;
	logic [NPORT-1:0] preferred_source_mask_r;
	logic [NPORT*NQ-1:0] queue_frame_cut_r;
	logic [NPORT-1:0] queue_drain_disable_r;
	logic [NPORT-1:0] flow_hold_enable_r;
	logic [CW-1:0] total_flag_set_level_r;
	logic [CW-1:0] total_flag_clear_level_r;
	logic [CW-1:0] total_tail_drop_level_r;
	logic [CW-1:0] watermark_config_r [NGRP][2];
	logic [CW-1:0] pause_start_r [NPORT];
	logic [CW-1:0] pause_stop_r [NPORT];
	logic [CW-1:0] port_tail_drop_level_r [NPORT];
	logic [CW-1:0] use_r [NGRP][NPORT];
	logic [CW-1:0] peak_r [NGRP][NPORT];
	logic [CW-1:0] use_nxt [NGRP][NPORT];
	logic [CW-1:0] inc [NGRP][NPORT];
	logic [CW-1:0] dec [NGRP][NPORT];
	logic [CW-1:0] tot_mem_r;
	logic [CW-1:0] tot_ref_r;
	logic [CW-1:0] free_memory_count_r;
	logic [CW-1:0] free_reference_count_r;
	logic total_memory_flag_r;
	logic [NPORT-1:0] tail_hit_r;
	logic [PW-1:0] rr_last_r;
	sqp_bus_e bus_r;
	logic [11:0] addr_r;
	logic [31:0] rd_mux;
	logic wr_en;
	logic mem_ok;
	logic ref_ok;
	logic accept;

	assign wr_en = (bus_r == SQP_BUS_WR);

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// Reads take one wait state so a preceding write has landed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_r <= SQP_BUS_IDLE;
			addr_r <= 12'h000;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else begin
			case (bus_r)
				SQP_BUS_RD: begin
					hrdata <= rd_mux;
					hreadyout <= 1'b1;
					bus_r <= SQP_BUS_IDLE;
				end
				SQP_BUS_IDLE, SQP_BUS_WR: begin
					if (hsel && htrans[1] && hready) begin
						addr_r <= {haddr[11:2], 2'b00};
						bus_r <= hwrite ? SQP_BUS_WR : SQP_BUS_RD;
						hreadyout <= hwrite;
					end else begin
						bus_r <= SQP_BUS_IDLE;
					end
				end
				default: bus_r <= SQP_BUS_IDLE;
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		case (addr_r)
			OFF_FORCE: rd_mux[NPORT-1:0] = egress_forced_discard_r;
			OFF_IGR_RSV: rd_mux[NPORT-1:0] = ingress_reserved_only_mask_r;
			OFF_EGR_RSV: rd_mux[NPORT-1:0] = egress_reserved_only_mask_r;
			OFF_PREFER: rd_mux[NPORT-1:0] = preferred_source_mask_r;
			OFF_CUT: rd_mux[NPORT*NQ-1:0] = queue_frame_cut_r;
			OFF_DRAIN: rd_mux[NPORT-1:0] = queue_drain_disable_r;
			OFF_HOLD: rd_mux[NPORT-1:0] = flow_hold_enable_r;
			OFF_TOT_SET: rd_mux[CW-1:0] = total_flag_set_level_r;
			OFF_TOT_CLR: rd_mux[CW-1:0] = total_flag_clear_level_r;
			OFF_TOT_TAIL: rd_mux[CW-1:0] = total_tail_drop_level_r;
			OFF_FREE_MEM: rd_mux[CW-1:0] = free_memory_count_r;
			OFF_FREE_REF: rd_mux[CW-1:0] = free_reference_count_r;
			OFF_STATUS: rd_mux[NPORT:0] = {pause_req, total_memory_flag_r};
			default: rd_mux = 32'h00000000;
		endcase
		for (int g = 0; g < NGRP; g++) begin
			for (int k = 0; k < 2; k++) begin
				if (addr_r == OFF_WM + 12'(4 * (g * 2 + k)))
					rd_mux[CW-1:0] = watermark_config_r[g][k];
			end
			for (int p = 0; p < NPORT; p++) begin
				// Statistics mirror the watermark layout
				if (addr_r == OFF_CUR + 12'(4 * (g * NPORT + p)))
					rd_mux[CW-1:0] = use_r[g][p];
				if (addr_r == OFF_PEAK + 12'(4 * (g * NPORT + p)))
					rd_mux[CW-1:0] = peak_r[g][p];
			end
		end
		for (int p = 0; p < NPORT; p++) begin
			if (addr_r == OFF_P_START + 12'(4 * p))
				rd_mux[CW-1:0] = pause_start_r[p];
			if (addr_r == OFF_P_STOP + 12'(4 * p))
				rd_mux[CW-1:0] = pause_stop_r[p];
			if (addr_r == OFF_P_TAIL + 12'(4 * p))
				rd_mux[CW-1:0] = port_tail_drop_level_r[p];
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			egress_forced_discard_r <= MASK_RST;
			ingress_reserved_only_mask_r <= MASK_RST;
			egress_reserved_only_mask_r <= MASK_RST;
			preferred_source_mask_r <= MASK_RST;
			queue_frame_cut_r <= CUT_RST;
			queue_drain_disable_r <= MASK_RST;
			flow_hold_enable_r <= MASK_RST;
			total_flag_set_level_r <= LEVEL_RST;
			total_flag_clear_level_r <= LEVEL_RST;
			total_tail_drop_level_r <= LEVEL_RST;
			for (int g = 0; g < NGRP; g++) begin
				watermark_config_r[g][K_RSV] <= LEVEL_RST;
				watermark_config_r[g][K_SHR] <= LEVEL_RST;
			end
			for (int p = 0; p < NPORT; p++) begin
				pause_start_r[p] <= LEVEL_RST;
				pause_stop_r[p] <= LEVEL_RST;
				port_tail_drop_level_r[p] <= LEVEL_RST;
			end
		end else if (wr_en) begin
			case (addr_r)
				OFF_FORCE: egress_forced_discard_r <= hwdata[NPORT-1:0];
				OFF_IGR_RSV: ingress_reserved_only_mask_r <= hwdata[NPORT-1:0];
				OFF_EGR_RSV: egress_reserved_only_mask_r <= hwdata[NPORT-1:0];
				OFF_PREFER: preferred_source_mask_r <= hwdata[NPORT-1:0];
				OFF_CUT: queue_frame_cut_r <= hwdata[NPORT*NQ-1:0];
				OFF_DRAIN: queue_drain_disable_r <= hwdata[NPORT-1:0];
				OFF_HOLD: flow_hold_enable_r <= hwdata[NPORT-1:0];
				OFF_TOT_SET: total_flag_set_level_r <= hwdata[CW-1:0];
				OFF_TOT_CLR: total_flag_clear_level_r <= hwdata[CW-1:0];
				OFF_TOT_TAIL: total_tail_drop_level_r <= hwdata[CW-1:0];
				default: ;
			endcase
			for (int g = 0; g < NGRP; g++) begin
				for (int k = 0; k < 2; k++) begin
					if (addr_r == OFF_WM + 12'(4 * (g * 2 + k)))
						watermark_config_r[g][k] <= hwdata[CW-1:0];
				end
			end
			for (int p = 0; p < NPORT; p++) begin
				if (addr_r == OFF_P_START + 12'(4 * p))
					pause_start_r[p] <= hwdata[CW-1:0];
				if (addr_r == OFF_P_STOP + 12'(4 * p))
					pause_stop_r[p] <= hwdata[CW-1:0];
				if (addr_r == OFF_P_TAIL + 12'(4 * p))
					port_tail_drop_level_r[p] <= hwdata[CW-1:0];
			end
		end
	end

	// ----------------------------------------
	// Admission check
	// ----------------------------------------
	// Shared area counts as exceeded for reserved-only ports
	always_comb begin
		mem_ok = (use_r[G_BUF_I][adm_src] < watermark_config_r[G_BUF_I][K_RSV])
			|| (use_r[G_BUF_E][adm_dst] < watermark_config_r[G_BUF_E][K_RSV])
			|| (!ingress_reserved_only_mask_r[adm_src]
			&& !egress_reserved_only_mask_r[adm_dst]
			&& tot_mem_r < watermark_config_r[G_BUF_I][K_SHR]
			&& tot_mem_r < watermark_config_r[G_BUF_E][K_SHR]);
		ref_ok = (use_r[G_REF_I][adm_src] < watermark_config_r[G_REF_I][K_RSV])
			|| (use_r[G_REF_E][adm_dst] < watermark_config_r[G_REF_E][K_RSV])
			|| (!ingress_reserved_only_mask_r[adm_src]
			&& !egress_reserved_only_mask_r[adm_dst]
			&& tot_ref_r < watermark_config_r[G_REF_I][K_SHR]
			&& tot_ref_r < watermark_config_r[G_REF_E][K_SHR]);
		accept = adm_valid && mem_ok && ref_ok;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adm_done <= 1'b0;
			adm_verdict <= SQP_ACCEPT;
		end else begin
			adm_done <= adm_valid;
			if (adm_valid) begin
				if (accept)
					adm_verdict <= SQP_ACCEPT;
				else if (egress_forced_discard_r[adm_dst])
					adm_verdict <= SQP_DROP;
				else if (flow_hold_enable_r[adm_src])
					adm_verdict <= SQP_HOLD;
				else
					adm_verdict <= SQP_DROP;
			end
		end
	end

	// ----------------------------------------
	// Consumption counters
	// ----------------------------------------
	always_comb begin
		for (int g = 0; g < NGRP; g++) begin
			for (int p = 0; p < NPORT; p++) begin
				inc[g][p] = '0;
				dec[g][p] = '0;
			end
		end
		if (wr_valid) begin
			inc[G_BUF_I][wr_src] = CW'(wr_bytes);
			inc[G_BUF_E][wr_dst] = CW'(wr_bytes);
		end
		if (accept) begin
			inc[G_REF_I][adm_src] = 20'h00001;
			inc[G_REF_E][adm_dst] = 20'h00001;
		end
		if (rel_valid) begin
			dec[G_BUF_I][rel_src] = CW'(rel_bytes);
			dec[G_BUF_E][rel_dst] = CW'(rel_bytes);
			if (rel_frame) begin
				dec[G_REF_I][rel_src] = 20'h00001;
				dec[G_REF_E][rel_dst] = 20'h00001;
			end
		end
	end

	for (genvar g = 0; g < NGRP; g++) begin : g_grp
		for (genvar p = 0; p < NPORT; p++) begin : g_port
			assign use_nxt[g][p] = use_r[g][p] + inc[g][p] - dec[g][p];
			// Writing a peak register restarts it from the current use
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					use_r[g][p] <= '0;
					peak_r[g][p] <= '0;
				end else begin
					use_r[g][p] <= use_nxt[g][p];
					if (wr_en && addr_r == OFF_PEAK + 12'(4 * (g * NPORT + p)))
						peak_r[g][p] <= use_nxt[g][p];
					else if (use_nxt[g][p] > peak_r[g][p])
						peak_r[g][p] <= use_nxt[g][p];
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tot_mem_r <= '0;
			tot_ref_r <= '0;
			free_memory_count_r <= MEM_TOTAL;
			free_reference_count_r <= REF_TOTAL;
		end else begin
			tot_mem_r <= tot_mem_r + inc[G_BUF_I][wr_src] - dec[G_BUF_I][rel_src];
			tot_ref_r <= tot_ref_r + inc[G_REF_I][adm_src] - dec[G_REF_I][rel_src];
			free_memory_count_r <= MEM_TOTAL - tot_mem_r;
			free_reference_count_r <= REF_TOTAL - tot_ref_r;
		end
	end

	// ----------------------------------------
	// Pause generation
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			total_memory_flag_r <= 1'b0;
		end else if (tot_mem_r > total_flag_set_level_r) begin
			total_memory_flag_r <= 1'b1;
		end else if (tot_mem_r < total_flag_clear_level_r) begin
			total_memory_flag_r <= 1'b0;
		end
	end

	// Between the two levels each flag keeps its state
	for (genvar p = 0; p < NPORT; p++) begin : g_pause
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				pause_req[p] <= 1'b0;
			end else if (!flow_hold_enable_r[p]) begin
				pause_req[p] <= 1'b0;
			end else if (use_r[G_BUF_I][p] < pause_stop_r[p]) begin
				pause_req[p] <= 1'b0;
			end else if (total_memory_flag_r && use_r[G_BUF_I][p] > pause_start_r[p]) begin
				pause_req[p] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Tail dropping
	// ----------------------------------------
	logic tail_now;
	assign tail_now = use_r[G_BUF_I][wr_src] > port_tail_drop_level_r[wr_src]
		&& tot_mem_r > total_tail_drop_level_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tail_hit_r <= MASK_RST;
			wr_done <= 1'b0;
			wr_discard <= 1'b0;
		end else begin
			wr_done <= wr_valid && wr_last;
			if (wr_valid && wr_last) begin
				// Mode bits play no part here
				wr_discard <= tail_hit_r[wr_src] || tail_now;
				tail_hit_r[wr_src] <= 1'b0;
			end else if (wr_valid && tail_now) begin
				tail_hit_r[wr_src] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Source arbitration and dequeue
	// ----------------------------------------
	logic [NPORT-1:0] cand;
	logic [NPORT-1:0] pick;
	logic [PW-1:0] pick_idx;
	always_comb begin
		cand = arb_req & preferred_source_mask_r;
		if (cand == '0)
			cand = arb_req;
		pick = '0;
		pick_idx = rr_last_r;
		for (int i = NPORT; i >= 1; i--) begin
			if (cand[PW'(rr_last_r + PW'(i))]) begin
				pick = '0;
				pick[PW'(rr_last_r + PW'(i))] = 1'b1;
				pick_idx = PW'(rr_last_r + PW'(i));
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rr_last_r <= '0;
			arb_done <= 1'b0;
			arb_gnt <= '0;
		end else begin
			arb_done <= arb_valid;
			if (arb_valid) begin
				arb_gnt <= pick;
				if (pick != '0)
					rr_last_r <= pick_idx;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_done <= 1'b0;
			dq_ok <= 1'b0;
			dq_len_out <= '0;
		end else begin
			dq_done <= dq_valid;
			if (dq_valid) begin
				dq_ok <= !queue_drain_disable_r[dq_port];
				if (queue_frame_cut_r[{dq_port, dq_queue}] && dq_len > CUT_LEN)
					dq_len_out <= CUT_LEN;
				else
					dq_len_out <= dq_len;
			end
		end
	end
endmodule // sqp_policer

// ===== bench/sqp_policer_props.sv
// Concurrent checks on the policing block's ports.
// Assumes it is bound onto sqp_policer, one clock, async low reset.
`timescale 1ns/1ps
module sqp_policer_props (
	// Clock and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	// Datapath strobes
	input wire logic adm_valid,
	input wire logic adm_done,
	input wire sqp_pkg::sqp_verdict_e adm_verdict,
	input wire logic wr_valid,
	input wire logic wr_last,
	input wire logic wr_done,
	input wire logic rel_valid,
	input wire logic arb_valid,
	input wire logic [sqp_pkg::NPORT-1:0] arb_req,
	input wire logic arb_done,
	input wire logic [sqp_pkg::NPORT-1:0] arb_gnt,
	input wire logic dq_valid,
	input wire logic [sqp_pkg::LW-1:0] dq_len,
	input wire logic dq_done,
	input wire logic [sqp_pkg::LW-1:0] dq_len_out,
	input wire logic [sqp_pkg::NPORT-1:0] pause_req
);
	import sqp_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_take;
	logic act;
	logic [5:0] act_h;
	assign rd_take = hsel && htrans[1] && hready && !hwrite;
	assign act = wr_valid || rel_valid || (hsel && htrans[1] && hready && hwrite);
	// Recent events that may move counters or levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_h <= 6'h00;
		end else begin
			act_h <= {act_h[4:0], act};
		end
	end
	a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_wait_cause: assert property (!hreadyout |-> $past(rd_take))
		else $error("wait state without read");
	a_adm_answer: assert property (adm_valid |=> adm_done && $onehot(adm_verdict))
		else $error("admission answer missing");
	a_adm_pulse: assert property (adm_done |-> $past(adm_valid))
		else $error("admission done without request");
	a_wr_answer: assert property (wr_valid && wr_last |=> wr_done)
		else $error("write done missing");
	a_wr_pulse: assert property (wr_done |-> $past(wr_valid && wr_last))
		else $error("write done without last beat");
	a_arb_grant: assert property (arb_valid |=> arb_done && $onehot0(arb_gnt)
		&& (arb_gnt & ~$past(arb_req)) == 4'h0 && ((arb_gnt != 4'h0) == ($past(arb_req) != 4'h0)))
		else $error("grant not one of the requesters");
	a_dq_cut: assert property (dq_valid |=> dq_done && (dq_len_out == $past(dq_len)
		|| ($past(dq_len) > CUT_LEN && dq_len_out == CUT_LEN)))
		else $error("dequeue length wrong");
	a_pause_hold: assert property (!$stable(pause_req) |-> act_h != 6'h00)
		else $error("pause request moved without cause");
endmodule // sqp_policer_props

// ===== bench/sqp_mac_model.sv
// Port module model: halts its link partner while pause is requested.
// Assumes pause_req levels from the policing block on hclk.
`timescale 1ns/1ps
module sqp_mac_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pause requests in, halt state out
	input wire logic [sqp_pkg::NPORT-1:0] pause_req,
	output logic [sqp_pkg::NPORT-1:0] halted
);
	import sqp_pkg::*;
	// Pause requests stop the partner next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halted <= 4'h0;
		end else begin
			halted <= pause_req;
		end
	end
endmodule // sqp_mac_model

// ===== bench/testbench.sv
// Self-checking bench for the policing block.
// Assumes one AHB-Lite master and the port module model.
`timescale 1ns/1ps
module testbench;
	import sqp_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0, adm_src = 2'h0, adm_dst = 2'h0, wr_src = 2'h0, wr_dst = 2'h0;
	logic [1:0] rel_src = 2'h0, rel_dst = 2'h0, dq_port = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, r;
	logic adm_valid = 1'b0, wr_valid = 1'b0, wr_last = 1'b0, rel_valid = 1'b0;
	logic rel_frame = 1'b0, arb_valid = 1'b0, dq_valid = 1'b0;
	logic [0:0] dq_queue = 1'h0;
	logic [LW-1:0] wr_bytes = 14'h0, rel_bytes = 14'h0, dq_len = 14'h0, dq_len_out;
	logic [NPORT-1:0] arb_req = 4'h0, arb_gnt, pause_req, halted;
	logic [31:0] hrdata;
	logic hready, hreadyout, hresp, adm_done, wr_done, wr_discard, arb_done, dq_done, dq_ok;
	sqp_verdict_e adm_verdict;
	int n_mismatch = 0, checked = 0;
	assign hready = hreadyout;
	sqp_policer DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .adm_valid, .adm_src, .adm_dst, .adm_done,
		.adm_verdict, .wr_valid, .wr_last, .wr_src, .wr_dst, .wr_bytes, .wr_done, .wr_discard,
		.rel_valid, .rel_frame, .rel_src, .rel_dst, .rel_bytes, .arb_valid, .arb_req,
		.arb_done, .arb_gnt, .dq_valid, .dq_port, .dq_queue, .dq_len, .dq_done, .dq_ok,
		.dq_len_out, .pause_req);
	sqp_mac_model u_mac (.hclk, .hresetn, .pause_req, .halted);
	initial begin
		forever #5 hclk = ~hclk;
	end
	// ----
	// Bus and datapath tasks
	// ----
	task results;
		if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			results();
		end
	endtask
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		r = hrdata;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk("hrdata", e, r);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task adm(input logic [1:0] s, input logic [1:0] d, input sqp_verdict_e e);
		@(posedge hclk);
		adm_valid <= 1'b1;
		adm_src <= s;
		adm_dst <= d;
		@(posedge hclk);
		adm_valid <= 1'b0;
		#1;
		chk("adm_verdict", e, adm_verdict);
	endtask
	task beat(input logic [1:0] s, input logic [1:0] d, input logic [13:0] b, input logic l,
		input logic e);
		@(posedge hclk);
		wr_valid <= 1'b1;
		wr_last <= l;
		wr_src <= s;
		wr_dst <= d;
		wr_bytes <= b;
		@(posedge hclk);
		wr_valid <= 1'b0;
		#1;
		if (l) chk("wr_discard", e, wr_discard);
	endtask
	task rel(input logic [1:0] s, input logic [1:0] d, input logic [13:0] b, input logic f);
		@(posedge hclk);
		rel_valid <= 1'b1;
		rel_src <= s;
		rel_dst <= d;
		rel_bytes <= b;
		rel_frame <= f;
		@(posedge hclk);
		rel_valid <= 1'b0;
	endtask
	task arb(input logic [3:0] q, input logic [3:0] e);
		@(posedge hclk);
		arb_valid <= 1'b1;
		arb_req <= q;
		@(posedge hclk);
		arb_valid <= 1'b0;
		#1;
		chk("arb_gnt", e, arb_gnt);
	endtask
	task dq(input logic [1:0] p, input logic q, input logic [13:0] n, input logic eok,
		input logic [13:0] e);
		@(posedge hclk);
		dq_valid <= 1'b1;
		dq_port <= p;
		dq_queue <= q;
		dq_len <= n;
		@(posedge hclk);
		dq_valid <= 1'b0;
		#1;
		chk("dq_ok", eok, dq_ok);
		if (eok) chk("dq_len_out", e, dq_len_out);
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(12'h028, 32'h80000);
		rd(12'h02C, 32'h0157C);
		rd(12'h05C, 32'hFFFFF);
		ahb(1'b1, 12'h028, 32'h1);
		rd(12'h028, 32'h80000);
		ahb(1'b1, 12'h3FC, 32'h5);
		rd(12'h3FC, 32'h0);
		beat(2'h0, 2'h1, 14'h64, 1'b1, 1'b0);
		rd(12'h100, 32'h64);
		rd(12'h124, 32'h64);
		rd(12'h028, 32'h7FF9C);
		rel(2'h0, 2'h1, 14'h64, 1'b0);
		rd(12'h100, 32'h0);
		rd(12'h140, 32'h64);
		adm(2'h0, 2'h1, SQP_ACCEPT);
		rd(12'h110, 32'h1);
		rd(12'h134, 32'h1);
		rd(12'h02C, 32'h0157B);
		rel(2'h0, 2'h1, 14'h0, 1'b1);
		ahb(1'b1, 12'h040, 32'h0);
		ahb(1'b1, 12'h050, 32'h0);
		adm(2'h0, 2'h1, SQP_ACCEPT);
		ahb(1'b1, 12'h004, 32'h1);
		adm(2'h0, 2'h1, SQP_DROP);
		ahb(1'b1, 12'h018, 32'h1);
		adm(2'h0, 2'h1, SQP_HOLD);
		ahb(1'b1, 12'h000, 32'h2);
		adm(2'h0, 2'h1, SQP_DROP);
		adm(2'h0, 2'h2, SQP_HOLD);
		ahb(1'b1, 12'h004, 32'h0);
		adm(2'h0, 2'h2, SQP_ACCEPT);
		ahb(1'b1, 12'h008, 32'h4);
		adm(2'h0, 2'h2, SQP_HOLD);
		adm(2'h1, 2'h2, SQP_DROP);
		ahb(1'b1, 12'h008, 32'h0);
		ahb(1'b1, 12'h048, 32'h0);
		ahb(1'b1, 12'h058, 32'h0);
		ahb(1'b1, 12'h04C, 32'h0);
		adm(2'h0, 2'h3, SQP_HOLD);
		ahb(1'b1, 12'h04C, 32'hFFFFF);
		ahb(1'b1, 12'h01C, 32'hC8);
		ahb(1'b1, 12'h020, 32'h64);
		ahb(1'b1, 12'h060, 32'h96);
		ahb(1'b1, 12'h070, 32'h32);
		beat(2'h0, 2'h0, 14'hA0, 1'b1, 1'b0);
		rd(12'h030, 32'h0);
		beat(2'h0, 2'h0, 14'h8C, 1'b1, 1'b0);
		rd(12'h030, 32'h3);
		chk("halted", 4'h1, halted);
		rel(2'h0, 2'h0, 14'h96, 1'b0);
		rd(12'h030, 32'h3);
		rel(2'h0, 2'h0, 14'h3C, 1'b0);
		rd(12'h030, 32'h2);
		rel(2'h0, 2'h0, 14'h3C, 1'b0);
		rd(12'h030, 32'h0);
		chk("halted", 4'h0, halted);
		ahb(1'b1, 12'h080, 32'h64);
		ahb(1'b1, 12'h024, 32'h64);
		beat(2'h0, 2'h0, 14'hC8, 1'b0, 1'b0);
		beat(2'h0, 2'h0, 14'h8, 1'b1, 1'b1);
		beat(2'h1, 2'h0, 14'h8, 1'b1, 1'b0);
		ahb(1'b1, 12'h084, 32'h0);
		ahb(1'b1, 12'h024, 32'hFFFFF);
		beat(2'h1, 2'h0, 14'h8, 1'b1, 1'b0);
		ahb(1'b1, 12'h024, 32'h64);
		beat(2'h1, 2'h0, 14'h8, 1'b1, 1'b1);
		ahb(1'b1, 12'h140, 32'h0);
		rd(12'h140, 32'hEE);
		arb(4'h1, 4'h1);
		arb(4'hF, 4'h2);
		arb(4'hF, 4'h4);
		arb(4'hB, 4'h8);
		arb(4'hB, 4'h1);
		ahb(1'b1, 12'h00C, 32'h4);
		arb(4'hF, 4'h4);
		arb(4'hB, 4'h8);
		arb(4'h0, 4'h0);
		ahb(1'b1, 12'h010, 32'h8);
		dq(2'h1, 1'b1, 14'hC8, 1'b1, CUT_LEN);
		dq(2'h1, 1'b1, 14'h5D, 1'b1, CUT_LEN);
		dq(2'h1, 1'b1, 14'h3C, 1'b1, 14'h3C);
		dq(2'h1, 1'b0, 14'hC8, 1'b1, 14'hC8);
		ahb(1'b1, 12'h014, 32'h4);
		dq(2'h2, 1'b0, 14'h32, 1'b0, 14'h32);
		dq(2'h1, 1'b0, 14'h32, 1'b1, 14'h32);
		results();
	end
endmodule // testbench

bind sqp_policer sqp_policer_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .adm_valid, .adm_done, .adm_verdict, .wr_valid, .wr_last, .wr_done,
	.rel_valid, .arb_valid, .arb_req, .arb_done, .arb_gnt, .dq_valid, .dq_len, .dq_done,
	.dq_len_out, .pause_req);
